// File: gwt_regs.vh
// constants and register map of the gate window timer
`ifndef GWT_REGS_VH
`define GWT_REGS_VH
`define GWT_ADDR_PROG      4'h0
`define GWT_ADDR_STATUS    4'h4
`define GWT_PROG_DIGIT_LSB 0
`define GWT_PROG_CMD_LSB   8
`define GWT_PROG_NEW_BIT   12
`define GWT_CMD_MANT       2'h0
`define GWT_CMD_EXP        2'h1
`define GWT_CMD_RATIO      2'h2
`define GWT_CMD_APPLY      2'h3
`define GWT_RST_MANT       12'h001
`define GWT_RST_EXP        4'h0
`define GWT_RST_RATIO      2'h0
`define GWT_RATIO_MIN      2'h0
`define GWT_RATIO_2TO1     2'h1
`define GWT_RATIO_1TO1     2'h2
`define GWT_RATIO_EXT      2'h3
`define GWT_EXP_MAX        4'h7
`define GWT_CLK_MHZ        50
`define GWT_TICK10_MHZ     10
`define GWT_TICK10_DIV     ((`GWT_CLK_MHZ / `GWT_TICK10_MHZ) - 1)
`define GWT_PRE_DIV        4
`define GWT_RESP_OKAY      2'h0
`define GWT_RESP_SLVERR    2'h2
`endif

// File: gwt_bcd_digit.v
// one decade of the bcd count chain
`include "gwt_regs.vh"
module gwt_bcd_digit (
	input  wire       clk_i,
	input  wire       reset_n_i,
	input  wire       clear_i,
	input  wire       count_i,
	output reg  [3:0] digit_o,
	output wire       carry_o
);
	assign carry_o = count_i & (digit_o == 4'h9);

	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			digit_o <= 4'h0;
		else if (clear_i)
			digit_o <= 4'h0;
		else if (count_i)
			digit_o <= (digit_o == 4'h9) ? 4'h0 : digit_o + 4'h1;
	end
endmodule // gwt_bcd_digit

// File: gwt_top.v
// gate window timer: program registers, bcd count chain and gate sequencer
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`include "gwt_regs.vh"
module gwt_top (
	input  wire        clk_i,
	input  wire        reset_n_i,
	input  wire [3:0]  s_axi_awaddr_i,
	input  wire        s_axi_awvalid_i,
	output reg         s_axi_awready_o,
	input  wire [31:0] s_axi_wdata_i,
	input  wire [3:0]  s_axi_wstrb_i,
	input  wire        s_axi_wvalid_i,
	output reg         s_axi_wready_o,
	output reg  [1:0]  s_axi_bresp_o,
	output reg         s_axi_bvalid_o,
	input  wire        s_axi_bready_i,
	input  wire [3:0]  s_axi_araddr_i,
	input  wire        s_axi_arvalid_i,
	output reg         s_axi_arready_o,
	output reg  [31:0] s_axi_rdata_o,
	output reg  [1:0]  s_axi_rresp_o,
	output reg         s_axi_rvalid_o,
	input  wire        s_axi_rready_i,
	input  wire        armed_i,
	input  wire        ext_start_i,
	input  wire        ext_stop_i,
	input  wire        transfer_window_i,
	input  wire        system_hold_request_i,
	input  wire        park_both_n_i,
	output reg         gate_n_o,
	output reg         dead_n_o,
	output reg         ratio_carry_o,
	output reg         deadtime_overrun_flag_n_o
);
	localparam ST_ARM  = 2'h0;
	localparam ST_MEAS = 2'h1;
	localparam ST_DEAD = 2'h2;

	reg  [11:0] mant_hold_reg;
	reg  [3:0]  exp_hold_reg;
	reg  [1:0]  ratio_hold_reg;
	reg  [11:0] mant_reg;
	reg  [3:0]  exp_reg;
	reg  [1:0]  ratio_reg;
	reg  [1:0]  state_reg;
	reg  [2:0]  tick10_cnt_reg;
	reg  [2:0]  div5_cnt_reg;
	reg         half_reg;
	reg         ext_started_reg;
	reg         dead_done_reg;
	reg         overrun_reg;
	reg         aw_got_reg;
	reg         w_got_reg;
	reg  [3:0]  aw_addr_reg;
	reg  [31:0] wdata_reg;
	reg  [3:0]  wstrb_reg;
	reg         apply_reg;
	wire        tick10;
	wire        tick2;
	wire        tick1us;
	wire        unit_tick;
	wire        count_freeze_n;
	wire [9:0]  carry;
	wire [9:0]  dig_en;
	wire [39:0] chain;
	wire [7:0]  taps;
	wire [2:0]  tap_sel;
	wire [11:0] mant_eff;
	wire        window_done;
	wire        chain_clear;
	wire        wr_fire;
	wire        rd_fire;
	wire        status_read;
	wire [1:0]  wr_cmd;
	wire [3:0]  wr_digit;
	reg  [1:0]  state_next;

	// 50 mhz down to the 10 mhz count pulse
	assign tick10 = (tick10_cnt_reg == `GWT_TICK10_DIV);
	assign tick2 = tick10 & (div5_cnt_reg == `GWT_PRE_DIV);
	// final halving gives the 1 us unit
	assign tick1us = tick2 & half_reg;

	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			tick10_cnt_reg <= 3'h0;
			div5_cnt_reg <= 3'h0;
			half_reg <= 1'b0;
		end
		else
		begin
			tick10_cnt_reg <= tick10 ? 3'h0 : tick10_cnt_reg + 3'h1;
			if (tick10)
				div5_cnt_reg <= (div5_cnt_reg == `GWT_PRE_DIV) ? 3'h0 : div5_cnt_reg + 3'h1;
			if (tick2)
				half_reg <= ~half_reg;
		end
	end

	// chain runs only while a window or a timed dead interval is in progress
	assign count_freeze_n = ((state_reg == ST_MEAS) ||
		((state_reg == ST_DEAD) && (ratio_reg != `GWT_RATIO_EXT) &&
		(ratio_reg != `GWT_RATIO_MIN))) && !system_hold_request_i;
	// in 2:1 the dead phase counts twice as fast, so it lasts half the window
	assign unit_tick = ((state_reg == ST_DEAD) && (ratio_reg == `GWT_RATIO_2TO1)) ?
		tick2 : tick1us;

	// digits 0..6 are the decade scaler, 7..9 the mantissa counter
	assign taps = {carry[6:0], unit_tick & count_freeze_n};
	assign tap_sel = (exp_reg > `GWT_EXP_MAX) ? 3'h7 : exp_reg[2:0];
	assign dig_en[0] = unit_tick & count_freeze_n;
	assign dig_en[7] = taps[tap_sel];

	genvar gi;
	generate
		for (gi = 0; gi < 10; gi = gi + 1)
		begin : g_dig
			if ((gi != 0) && (gi != 7))
			begin : g_casc
				assign dig_en[gi] = carry[gi-1];
			end
			gwt_bcd_digit u_dig (
				.clk_i     (clk_i),
				.reset_n_i (reset_n_i),
				.clear_i   (chain_clear),
				.count_i   (dig_en[gi]),
				.digit_o   (chain[4*gi+3:4*gi]),
				.carry_o   (carry[gi])
			);
		end
	endgenerate

	// a zero mantissa is taken as one unit, the shortest window
	assign mant_eff = (mant_reg == 12'h000) ? 12'h001 : mant_reg;
	assign window_done = count_freeze_n && (chain[39:28] == mant_eff);
	assign chain_clear = apply_reg || window_done || (state_reg == ST_ARM);

	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_ARM:
				if (armed_i && !system_hold_request_i)
					state_next = ST_MEAS;
			ST_MEAS:
				if (window_done)
				begin
					if (ratio_reg == `GWT_RATIO_MIN)
						state_next = ST_ARM;
					else
						state_next = ST_DEAD;
				end
			ST_DEAD:
				if (ratio_reg == `GWT_RATIO_EXT)
				begin
					if (ext_started_reg && ext_stop_i)
						state_next = ST_ARM;
				end
				else if (window_done)
					state_next = ST_ARM;
			default:
				state_next = ST_ARM;
		endcase
		if (system_hold_request_i || apply_reg)
			state_next = ST_ARM;
	end

	assign status_read = rd_fire && (s_axi_araddr_i == `GWT_ADDR_STATUS);

	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_reg <= ST_ARM;
			ext_started_reg <= 1'b0;
			dead_done_reg <= 1'b0;
			overrun_reg <= 1'b0;
			ratio_carry_o <= 1'b0;
			gate_n_o <= 1'b1;
			dead_n_o <= 1'b1;
			deadtime_overrun_flag_n_o <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			if (state_reg != ST_DEAD)
				ext_started_reg <= 1'b0;
			else if (ext_start_i)
				ext_started_reg <= 1'b1;
			if ((ratio_reg == `GWT_RATIO_2TO1) && window_done)
				ratio_carry_o <= ~ratio_carry_o;
			else if (ratio_reg != `GWT_RATIO_2TO1)
				ratio_carry_o <= 1'b0;
			// an interval just ended; partner not armed means real dead is longer
			dead_done_reg <= (state_reg != ST_ARM) && (state_next == ST_ARM) &&
				!system_hold_request_i && !apply_reg;
			// set beats the clear from a status read
			if (dead_done_reg && !armed_i && transfer_window_i)
				overrun_reg <= 1'b1;
			else if (status_read)
				overrun_reg <= 1'b0;
			deadtime_overrun_flag_n_o <= ~((dead_done_reg && !armed_i &&
				transfer_window_i) || (overrun_reg && !status_read));
			if (!park_both_n_i)
			begin
				gate_n_o <= 1'b1;
				dead_n_o <= 1'b1;
			end
			else
			begin
				gate_n_o <= ~(state_next == ST_MEAS);
				dead_n_o <= (state_next == ST_MEAS);
			end
		end
	end

	// axi4-lite write side: address and data taken in either order
	assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid_o;
	assign wr_cmd = wdata_reg[`GWT_PROG_CMD_LSB+1:`GWT_PROG_CMD_LSB];
	assign wr_digit = wdata_reg[`GWT_PROG_DIGIT_LSB+3:`GWT_PROG_DIGIT_LSB];

	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `GWT_RESP_OKAY;
			aw_got_reg <= 1'b0;
			w_got_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
			apply_reg <= 1'b0;
			mant_hold_reg <= `GWT_RST_MANT;
			exp_hold_reg <= `GWT_RST_EXP;
			ratio_hold_reg <= `GWT_RST_RATIO;
			mant_reg <= `GWT_RST_MANT;
			exp_reg <= `GWT_RST_EXP;
			ratio_reg <= `GWT_RST_RATIO;
		end
		else
		begin
			apply_reg <= 1'b0;
			s_axi_awready_o <= !aw_got_reg && !s_axi_awready_o && s_axi_awvalid_i;
			s_axi_wready_o <= !w_got_reg && !s_axi_wready_o && s_axi_wvalid_i;
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_got_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_got_reg <= 1'b1;
				wdata_reg <= s_axi_wdata_i;
				wstrb_reg <= s_axi_wstrb_i;
			end
			if (s_axi_bvalid_o && s_axi_bready_i)
				s_axi_bvalid_o <= 1'b0;
			if (wr_fire)
			begin
				aw_got_reg <= 1'b0;
				w_got_reg <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= (aw_addr_reg == `GWT_ADDR_PROG) ?
					`GWT_RESP_OKAY : `GWT_RESP_SLVERR;
				// command and digit share the two low byte lanes
				if ((aw_addr_reg == `GWT_ADDR_PROG) && (wstrb_reg[1:0] == 2'h3))
				begin
					case (wr_cmd)
						`GWT_CMD_MANT:
							if (wdata_reg[`GWT_PROG_NEW_BIT])
								mant_hold_reg <= {8'h00, wr_digit};
							else
								mant_hold_reg <= {mant_hold_reg[7:0], wr_digit};
						`GWT_CMD_EXP:
							exp_hold_reg <= wr_digit;
						`GWT_CMD_RATIO:
							ratio_hold_reg <= wr_digit[1:0];
						`GWT_CMD_APPLY:
						begin
							apply_reg <= 1'b1;
							mant_reg <= mant_hold_reg;
							exp_reg <= exp_hold_reg;
							ratio_reg <= ratio_hold_reg;
						end
						default:
							apply_reg <= 1'b0;
					endcase
				end
			end
		end
	end

	// axi4-lite read side, one read at a time
	assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;

	always @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h0;
			s_axi_rresp_o <= `GWT_RESP_OKAY;
		end
		else
		begin
			s_axi_arready_o <= !s_axi_arready_o && !s_axi_rvalid_o && s_axi_arvalid_i;
			if (s_axi_rvalid_o && s_axi_rready_i)
				s_axi_rvalid_o <= 1'b0;
			if (rd_fire)
			begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rresp_o <= `GWT_RESP_OKAY;
				case (s_axi_araddr_i)
					`GWT_ADDR_PROG:
						s_axi_rdata_o <= {10'h000, ratio_hold_reg, exp_hold_reg, mant_hold_reg,
							ratio_reg, exp_reg[1:0]};
					`GWT_ADDR_STATUS:
						s_axi_rdata_o <= {mant_reg, 8'h00, exp_reg, 3'h0,
							overrun_reg, 2'h0, state_reg};
					default:
					begin
						s_axi_rdata_o <= 32'h0;
						s_axi_rresp_o <= `GWT_RESP_SLVERR;
					end
				endcase
			end
		end
	end
endmodule // gwt_top

// File: gwt_top_chk.sv
// assertion checker for the gate window timer ports
module gwt_top_chk (
	input wire       clk_i,
	input wire       reset_n_i,
	input wire [3:0] s_axi_araddr_i,
	input wire       s_axi_arvalid_i,
	input wire       s_axi_arready_o,
	input wire       s_axi_rvalid_o,
	input wire       s_axi_rready_i,
	input wire       s_axi_awvalid_i,
	input wire       s_axi_awready_o,
	input wire       s_axi_wvalid_i,
	input wire       s_axi_wready_o,
	input wire       s_axi_bvalid_o,
	input wire       armed_i,
	input wire       transfer_window_i,
	input wire       system_hold_request_i,
	input wire       park_both_n_i,
	input wire       gate_n_o,
	input wire       dead_n_o,
	input wire       deadtime_overrun_flag_n_o
);
	// any read answer counts as a possible clear, the exact clear cycle is open
	wire rd_any = (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == 4'h4)
		|| (s_axi_rvalid_o && s_axi_rready_i);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	sequence s_wtake;
		s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
	endsequence
	property p_dead_comp;
		park_both_n_i && $past(park_both_n_i) && $past(reset_n_i, 3) |-> dead_n_o == !gate_n_o;
	endproperty
	a_dead_comp: assert property (p_dead_comp) else $error("dead not complement");
	property p_park;
		!park_both_n_i ##1 !park_both_n_i |-> gate_n_o && dead_n_o;
	endproperty
	a_park: assert property (p_park) else $error("park not high");
	property p_arm;
		$fell(gate_n_o) && $past(park_both_n_i, 2) |-> $past(armed_i)
			&& !$past(system_hold_request_i);
	endproperty
	a_arm: assert property (p_arm) else $error("gate without ready");
	property p_hold;
		system_hold_request_i ##1 system_hold_request_i |-> gate_n_o;
	endproperty
	a_hold: assert property (p_hold) else $error("gate active in hold");
	property p_ovr_quiet;
		$fell(deadtime_overrun_flag_n_o) |-> $past(transfer_window_i)
			|| $past(transfer_window_i, 2) || $past(transfer_window_i, 3);
	endproperty
	a_ovr_quiet: assert property (p_ovr_quiet) else $error("overrun set");
	property p_ovr_keep;
		!deadtime_overrun_flag_n_o && !rd_any && !$past(rd_any) |=> !deadtime_overrun_flag_n_o;
	endproperty
	a_ovr_keep: assert property (p_ovr_keep) else $error("overrun lost");
	property p_bresp;
		s_wtake |=> ##1 s_axi_bvalid_o;
	endproperty
	a_bresp: assert property (p_bresp) else $error("write answer late");
	property p_rdly;
		s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
	endproperty
	a_rdly: assert property (p_rdly) else $error("read answer late");
endmodule // gwt_top_chk
bind gwt_top gwt_top_chk chk (.*);

// File: gwt_mainframe.sv
// model of the counting mainframe that arms and takes the gate
module gwt_mainframe (
	input  wire clk_i,
	input  wire reset_n_i,
	input  wire gate_n_i,
	input  wire slow_i,
	output wire armed_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rearm_cnt;
	// restarts at each gate so a slow partner re-arms late after it
	always @(posedge clk_i or negedge reset_n_i)
		if (!reset_n_i)
			rearm_cnt <= 8'h00;
		else if (!gate_n_i)
			rearm_cnt <= 8'h00;
		else if (rearm_cnt != 8'hff)
			rearm_cnt <= rearm_cnt + 8'h01;
	assign armed_o = !slow_i || (gate_n_i && rearm_cnt > 8'hc8);
endmodule // gwt_mainframe

// File: tb.sv
// self-checking bench for the gate window timer
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 0, reset_n_i = 0, slow = 0, rc_q = 0;
	logic [3:0]  s_axi_awaddr_i = 0, s_axi_araddr_i = 0, s_axi_wstrb_i = 4'hf;
	logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, d;
	logic        s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
	logic        s_axi_arvalid_i = 0, s_axi_rready_i = 0, armed_i, ext_start_i = 0, ext_stop_i = 0;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, r;
	logic        transfer_window_i = 0, system_hold_request_i = 0, park_both_n_i = 1;
	logic        gate_n_o, dead_n_o, ratio_carry_o, deadtime_overrun_flag_n_o;
	int          mismatches = 0, n_checks = 0, cyc = 0, lo, hi, tg, ov, k;
	int          hmin[3] = '{0, 700, 1448};
	int          hmax[3] = '{5, 800, 1552};
	gwt_top dut (.*);
	gwt_mainframe mf (.clk_i(clk_i), .reset_n_i(reset_n_i), .gate_n_i(gate_n_o),
		.slow_i(slow), .armed_o(armed_i));
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		rc_q <= ratio_carry_o;
		tg += (rc_q !== ratio_carry_o);
		cyc++;
		if (cyc == 60000)
		begin
			mismatches++;
			conclude();
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkr(input string nm, input int v, input int a, input int b);
		n_checks++;
		if (v < a || v > b)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, a, b, v);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= v;
		s_axi_awvalid_i <= 1'h1;
		s_axi_wvalid_i <= 1'h1;
		s_axi_bready_i <= 1'h1;
		do
		begin
			@(posedge clk_i);
			if (s_axi_awready_o)
				s_axi_awvalid_i <= 1'h0;
			if (s_axi_wready_o)
				s_axi_wvalid_i <= 1'h0;
		end
		while (s_axi_bvalid_o !== 1'h1);
		rs = s_axi_bresp_o;
		s_axi_bready_i <= 1'h0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'h1;
		s_axi_rready_i <= 1'h1;
		do
		begin
			@(posedge clk_i);
			if (s_axi_arready_o)
				s_axi_arvalid_i <= 1'h0;
		end
		while (s_axi_rvalid_o !== 1'h1);
		v = s_axi_rdata_o;
		rs = s_axi_rresp_o;
		s_axi_rready_i <= 1'h0;
	endtask
	task automatic pw(input logic [1:0] c, input logic [3:0] g, input logic nb);
		wr(4'h0, {19'h0, nb, 2'h0, c, 4'h0, g}, r);
		chk("prog bresp", 2'h0, r);
	endtask
	task automatic edge_to(input logic v);
		while (gate_n_o !== v)
			@(posedge clk_i);
	endtask
	task automatic meas();
		edge_to(1'h1);
		edge_to(1'h0);
		lo = 0;
		hi = 0;
		tg = 0;
		for (; gate_n_o === 1'h0; lo++)
			@(posedge clk_i);
		for (; gate_n_o === 1'h1; hi++)
			@(posedge clk_i);
	endtask
	task automatic quiet(input int n);
		lo = 0;
		hi = 0;
		ov = 0;
		repeat (n)
		begin
			@(posedge clk_i);
			lo += (gate_n_o !== 1'h1);
			hi += (dead_n_o !== 1'h1);
			ov += (deadtime_overrun_flag_n_o !== 1'h1);
		end
	endtask
	initial
	begin
		repeat (5) @(posedge clk_i);
		reset_n_i <= 1'h1;
		rd(4'h4, d, r);
		chk("status reset", 32'h0010_0000, d & 32'hfff0_0f00);
		rd(4'h8, d, r);
		chk("unmapped rresp", 2'h2, r);
		wr(4'hc, 32'h0, r);
		chk("unmapped bresp", 2'h2, r);
		pw(2'h0, 4'h1, 1'h1);
		pw(2'h0, 4'h2, 1'h0);
		pw(2'h0, 4'h3, 1'h0);
		pw(2'h0, 4'h4, 1'h0);
		rd(4'h0, d, r);
		chk("mantissa hold", 12'h234, d[15:4]);
		// 3 x 10^1 us keeps each window at 1500 clocks
		pw(2'h0, 4'h3, 1'h1);
		pw(2'h1, 4'h1, 1'h0);
		for (k = 0; k < 3; k++)
		begin
			pw(2'h2, k[3:0], 1'h0);
			pw(2'h3, 4'h0, 1'h0);
			meas();
			chkr("gate width", lo, 1451, 1501);
			chkr("dead width", hi, hmin[k], hmax[k]);
			chkr("ratio carry", tg, k == 1, k == 1 ? 9 : 0);
		end
		rd(4'h4, d, r);
		chk("working set", 32'h0030_0100, d & 32'hfff0_0f00);
		pw(2'h2, 4'h3, 1'h0);
		pw(2'h3, 4'h0, 1'h0);
		// apply aborts to arm-wait for one cycle, so skip that short high first
		edge_to(1'h1);
		edge_to(1'h0);
		edge_to(1'h1);
		quiet(300);
		chk("ext dead idle", 0, lo);
		ext_start_i <= 1'h1;
		@(posedge clk_i);
		ext_start_i <= 1'h0;
		quiet(100);
		ext_stop_i <= 1'h1;
		@(posedge clk_i);
		ext_stop_i <= 1'h0;
		for (k = 0; gate_n_o === 1'h1 && k < 10; k++)
			@(posedge clk_i);
		chkr("ext stop to gate", k, 0, 3);
		system_hold_request_i <= 1'h1;
		quiet(2);
		quiet(3000);
		chk("hold gate", 0, lo);
		system_hold_request_i <= 1'h0;
		park_both_n_i <= 1'h0;
		quiet(2);
		quiet(200);
		chk("park gate dead", 0, lo + hi);
		park_both_n_i <= 1'h1;
		pw(2'h2, 4'h0, 1'h0);
		pw(2'h3, 4'h0, 1'h0);
		slow <= 1'h1;
		quiet(6000);
		chk("overrun masked", 0, ov);
		transfer_window_i <= 1'h1;
		quiet(4000);
		chkr("overrun raised", ov, 1, 4000);
		slow <= 1'h0;
		quiet(300);
		chk("overrun held", 300, ov);
		rd(4'h4, d, r);
		chk("overrun bit", 1'h1, d[4]);
		quiet(3);
		chk("overrun clear", 1'h1, deadtime_overrun_flag_n_o);
		conclude();
	end
endmodule // tb
